// ### design/lxo_cfg.svh
`ifndef LXO_CFG_SVH
`define LXO_CFG_SVH

// Register indexes; the byte address on the bus is four times the index.
`define LXO_IDX_LANE_EXT 12'h20b
`define LXO_IDX_SYNC_HDR 12'h20f
`define LXO_IDX_DOWNCONVERTER_CONFIG 12'h210
`define LXO_IDX_I_THR 12'h211
`define LXO_IDX_Q_THR 12'h212
`define LXO_IDX_OVERRANGE_PIN_CONFIG 12'h213
`define LXO_IDX_IRQ_STS 12'h218
`define LXO_IDX_IRQ_MASK 12'h219

// Reset values.
`define LXO_RST_LANE_EXT 8'h00
`define LXO_RST_SYNC_HDR 8'h00
`define LXO_RST_DOWNCONVERTER_CONFIG 8'h00
`define LXO_RST_I_THR 8'hf2
`define LXO_RST_Q_THR 8'hab
`define LXO_RST_OVERRANGE_PIN_CONFIG 8'h07
`define LXO_RST_IRQ_MASK 5'h00

// Field reset values, sized to the flip-flops that hold them.
`define LXO_RST_SH_MODE 2'h0
`define LXO_RST_GAIN 1'b0
`define LXO_RST_OVERRANGE_PIN_ENABLE 1'b0
`define LXO_RST_OVERRANGE_STRETCH_EXPONENT 3'h7

// Field positions.
`define LXO_EXT_SER_BIT 0
`define LXO_EXT_LANE_HI 7
`define LXO_EXT_LANE_LO 1
`define LXO_GAIN_BIT 0
`define LXO_OVERRANGE_PIN_ENABLE_BIT 3
`define LXO_OVERRANGE_STRETCH_EXPONENT_HI 2
`define LXO_OVERRANGE_STRETCH_EXPONENT_LO 0

// Sync header mode codes.
`define LXO_SH_CRC 2'h0
`define LXO_SH_FEC 2'h2

// Test pattern codes that the extension ramp replaces, and the ramp code.
`define LXO_PAT_OFF 4'h0
`define LXO_PAT_ALT 4'h5
`define LXO_PAT_RAMP 4'h4

// Shortest over-range pulse is this base times two to the exponent.
`define LXO_STRETCH_BASE 11'h008

// Interrupt status bit positions.
`define LXO_IRQ_CFG_BIT 4

`endif

// ### design/lxo_pkg.sv
package lxo_pkg;

  // One down-converter input sample pair.
  typedef struct packed {
    logic valid;
    logic [15:0] i;
    logic [15:0] q;
  } lxo_sample_s;

  // One down-converter output sample pair with its control bits.
  typedef struct packed {
    logic valid;
    logic [15:0] i;
    logic i_ovr;
    logic [15:0] q;
    logic q_ovr;
  } lxo_sample_out_s;

  // Per-lane controls towards the link layer and serializer.
  typedef struct packed {
    logic clk_en;
    logic ser_pwr;
    logic ser_clk;
    logic [3:0] pattern;
  } lxo_lane_s;

  // Sync header controls towards the 64b/66b framer.
  typedef struct packed {
    logic crc_en;
    logic fec_en;
    logic reserved_mode;
    logic [4:0] cmd;
  } lxo_sync_s;

endpackage

// ### design/lxo_stretch.sv
`timescale 1ns/1ns
`include "lxo_cfg.svh"

// Stretches a one-cycle over-range hit into a pin pulse of at least
// base times two to the exponent cycles; a new hit restarts the count.
module lxo_stretch (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic hit,
  input wire logic enable,
  input wire logic [2:0] exponent,
  // Pin.
  output logic pin
);

  logic [10:0] cnt_ff;
  logic [10:0] nxt_cnt;
  logic pin_ff;

  // Reload on every hit so that a run of hits keeps the pin high.
  always_comb begin
    if (hit) begin
      nxt_cnt = `LXO_STRETCH_BASE << exponent;
    end else if (cnt_ff != 11'h000) begin
      nxt_cnt = cnt_ff - 11'h001;
    end else begin
      nxt_cnt = 11'h000;
    end
  end

  // The counter runs while the pin is gated off, so enabling it later
  // shows only hits still inside their window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 11'h000;
      pin_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pin_ff <= enable && (nxt_cnt != 11'h000);
    end
  end

  assign pin = pin_ff;

endmodule

// ### design/lxo_top.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`include "lxo_cfg.svh"

// Notes on behaviour
// - Extension bits enable clocks of lanes B1-B7.
// - Added-serializer bit also powers extra serializers.
// - Extra lanes follow format and test pattern.
// - Extension-only lanes send ramp for pattern 0/5.
// - Channel power-down keeps extra lanes inactive.
// - Serializer clock needs all lower lanes enabled.
// - Sync header mode applies only to 64b/66b.
// - Mode 0 selects CRC-12, mode 2 FEC.
// - All sync header command fields sent zero.
// - Gain bit doubles down-converter output, else unity.
// - I control bit set at threshold zero.
// - Q control bit set at threshold one.
// - Pin enable clear holds over-range pins low.
// - Pins stretched to eight times two-power cycles.
module lxo_top (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link state from the rest of the back end.
  input wire logic serial_link_enable,
  input wire logic link_format_64b66b,
  input wire logic [7:0] link_format_lanes_b,
  input wire logic [3:0] link_test_pattern_select,
  input wire logic [1:0] channel_power_down,
  // Link B lane and sync header controls.
  output lxo_pkg::lxo_lane_s lane_b [8],
  output lxo_pkg::lxo_sync_s sync_hdr,
  // Down-converter streams, channel A at index 0 and B at index 1.
  input lxo_pkg::lxo_sample_s ddc_in [2],
  output lxo_pkg::lxo_sample_out_s ddc_out [2],
  // Over-range pins and interrupt.
  output logic overrange_out_a_low,
  output logic overrange_out_a_high,
  output logic overrange_out_b_low,
  output logic overrange_out_b_high,
  output logic irq
);

  // Magnitude of a signed sample; the most negative value fits unsigned.
  function automatic logic [15:0] lxo_abs(input logic [15:0] s);
    logic [16:0] e;
    e = {s[15], s};
    if (s[15]) begin
      e = ~e + 17'h00001;
    end
    return e[15:0];
  endfunction

  // Doubling with saturation instead of wrap, so a clip stays a clip.
  function automatic logic [15:0] lxo_gain(input logic [15:0] s,
                                           input logic dbl);
    logic [15:0] r;
    r = s;
    if (dbl) begin
      if (s[15] != s[14]) begin
        r = s[15] ? 16'h8000 : 16'h7fff;
      end else begin
        r = {s[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // Threshold is a fraction of full scale in steps of one 256th.
  function automatic logic lxo_over(input logic [15:0] s,
                                    input logic [7:0] thr);
    return lxo_abs(s) >= {1'b0, thr, 7'h00};
  endfunction

  // True when every lane below n has its lane enabled.
  function automatic logic lxo_lower_on(input logic [7:0] en,
                                        input int n);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k < n) begin
        ok = ok & en[k];
      end
    end
    return ok;
  endfunction

  logic [7:0] lane_ext_ff;
  logic [1:0] sync_mode_ff;
  logic gain_ff;
  logic [7:0] i_thr_ff;
  logic [7:0] q_thr_ff;
  logic overrange_pin_enable_ff;
  logic [2:0] overrange_stretch_exponent_ff;
  logic [4:0] irq_sts_ff;
  logic [4:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  lxo_pkg::lxo_sample_out_s ddc_out_ff [2];
  lxo_pkg::lxo_lane_s lane_b_ff [8];
  lxo_pkg::lxo_sync_s sync_ff;

  logic setup;
  logic wr_en;
  logic [11:0] idx;
  logic mapped;
  logic cfg_touch;
  logic [3:0] hit;
  logic [4:0] irq_set;
  logic [4:0] irq_clr;
  logic [31:0] nxt_rdata;
  logic [7:0] lane_on;
  logic [15:0] gi [2];
  logic [15:0] gq [2];

  // Decode; addresses must be word aligned.
  assign setup = psel && !penable;
  assign idx = paddr[13:2];
  assign wr_en = psel && penable && pwrite && !pslverr_ff;

  always_comb begin
    unique case (idx)
      `LXO_IDX_LANE_EXT, `LXO_IDX_SYNC_HDR, `LXO_IDX_DOWNCONVERTER_CONFIG,
      `LXO_IDX_I_THR, `LXO_IDX_Q_THR, `LXO_IDX_OVERRANGE_PIN_CONFIG,
      `LXO_IDX_IRQ_STS, `LXO_IDX_IRQ_MASK: begin
        mapped = (paddr[1:0] == 2'h0);
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read mux; reserved bits read as zero.
  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (idx)
      `LXO_IDX_LANE_EXT: begin
        nxt_rdata[7:0] = lane_ext_ff;
      end
      `LXO_IDX_SYNC_HDR: begin
        nxt_rdata[1:0] = sync_mode_ff;
      end
      `LXO_IDX_DOWNCONVERTER_CONFIG: begin
        nxt_rdata[`LXO_GAIN_BIT] = gain_ff;
      end
      `LXO_IDX_I_THR: begin
        nxt_rdata[7:0] = i_thr_ff;
      end
      `LXO_IDX_Q_THR: begin
        nxt_rdata[7:0] = q_thr_ff;
      end
      `LXO_IDX_OVERRANGE_PIN_CONFIG: begin
        nxt_rdata[`LXO_OVERRANGE_PIN_ENABLE_BIT] = overrange_pin_enable_ff;
        nxt_rdata[`LXO_OVERRANGE_STRETCH_EXPONENT_HI:`LXO_OVERRANGE_STRETCH_EXPONENT_LO] = overrange_stretch_exponent_ff;
      end
      `LXO_IDX_IRQ_STS: begin
        nxt_rdata[4:0] = irq_sts_ff;
      end
      `LXO_IDX_IRQ_MASK: begin
        nxt_rdata[4:0] = irq_mask_ff;
      end
      default: begin
        nxt_rdata = 32'h00000000;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle, so the access
  // phase completes at once with both from flip-flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h00000000 : nxt_rdata;
      pslverr_ff <= !mapped;
    end
  end

  assign prdata = prdata_ff;
  assign pready = psel && penable;
  assign pslverr = psel && penable && pslverr_ff;

  // Configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_ext_ff <= `LXO_RST_LANE_EXT;
      sync_mode_ff <= `LXO_RST_SH_MODE;
      gain_ff <= `LXO_RST_GAIN;
      i_thr_ff <= `LXO_RST_I_THR;
      q_thr_ff <= `LXO_RST_Q_THR;
      overrange_pin_enable_ff <= `LXO_RST_OVERRANGE_PIN_ENABLE;
      overrange_stretch_exponent_ff <= `LXO_RST_OVERRANGE_STRETCH_EXPONENT;
      irq_mask_ff <= `LXO_RST_IRQ_MASK;
    end else if (wr_en) begin
      unique case (idx)
        `LXO_IDX_LANE_EXT: begin
          lane_ext_ff <= pwdata[7:0];
        end
        `LXO_IDX_SYNC_HDR: begin
          sync_mode_ff <= pwdata[1:0];
        end
        `LXO_IDX_DOWNCONVERTER_CONFIG: begin
          gain_ff <= pwdata[`LXO_GAIN_BIT];
        end
        `LXO_IDX_I_THR: begin
          i_thr_ff <= pwdata[7:0];
        end
        `LXO_IDX_Q_THR: begin
          q_thr_ff <= pwdata[7:0];
        end
        `LXO_IDX_OVERRANGE_PIN_CONFIG: begin
          overrange_pin_enable_ff <= pwdata[`LXO_OVERRANGE_PIN_ENABLE_BIT];
          overrange_stretch_exponent_ff <= pwdata[`LXO_OVERRANGE_STRETCH_EXPONENT_HI:`LXO_OVERRANGE_STRETCH_EXPONENT_LO];
        end
        `LXO_IDX_IRQ_MASK: begin
          irq_mask_ff <= pwdata[4:0];
        end
        default: begin
          irq_mask_ff <= irq_mask_ff;
        end
      endcase
    end
  end

  // A lane or sync header write with the link running is still taken,
  // but flagged, since the link layer may be mid-frame.
  assign cfg_touch = wr_en && serial_link_enable &&
                     (idx == `LXO_IDX_LANE_EXT ||
                      idx == `LXO_IDX_SYNC_HDR);

  // Interrupt status: a new event beats a same-cycle clear.
  assign irq_set = {cfg_touch, hit};
  assign irq_clr = (wr_en && idx == `LXO_IDX_IRQ_STS) ?
                   pwdata[4:0] : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_ff <= 5'h00;
    end else begin
      irq_sts_ff <= (irq_sts_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_sts_ff & irq_mask_ff);

  // Lane enables: lane 0 comes only from the format, lanes 1-7 also
  // from the extension field; link B power-down wins over both.
  always_comb begin
    lane_on = link_format_lanes_b;
    lane_on[`LXO_EXT_LANE_HI:`LXO_EXT_LANE_LO] =
      link_format_lanes_b[7:1] |
      lane_ext_ff[`LXO_EXT_LANE_HI:`LXO_EXT_LANE_LO];
    if (channel_power_down[1]) begin
      lane_on = 8'h00;
    end
  end

  // Per-lane controls, registered so the link layer sees clean levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < 8; n++) begin
        lane_b_ff[n] <= '0;
      end
    end else begin
      for (int n = 0; n < 8; n++) begin
        lane_b_ff[n].clk_en <= lane_on[n];
        lane_b_ff[n].ser_pwr <= lane_on[n] && (link_format_lanes_b[n] ||
          lane_ext_ff[`LXO_EXT_SER_BIT]);
        lane_b_ff[n].ser_clk <= lane_on[n] && (link_format_lanes_b[n] ||
          lane_ext_ff[`LXO_EXT_SER_BIT]) &&
          lxo_lower_on(lane_on, n);
        if (!link_format_lanes_b[n] && lane_on[n] &&
            (link_test_pattern_select == `LXO_PAT_OFF ||
             link_test_pattern_select == `LXO_PAT_ALT)) begin
          lane_b_ff[n].pattern <= `LXO_PAT_RAMP;
        end else begin
          lane_b_ff[n].pattern <= link_test_pattern_select;
        end
      end
    end
  end

  assign lane_b = lane_b_ff;

  // Sync header selection; reserved codes enable neither check word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= '0;
    end else begin
      sync_ff.crc_en <= link_format_64b66b &&
                        sync_mode_ff == `LXO_SH_CRC;
      sync_ff.fec_en <= link_format_64b66b &&
                        sync_mode_ff == `LXO_SH_FEC;
      sync_ff.reserved_mode <= link_format_64b66b &&
                               sync_mode_ff[0];
      sync_ff.cmd <= 5'h00;
    end
  end

  assign sync_hdr = sync_ff;

  // Gain stage ahead of the level check; the check sees what is sent.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      gi[c] = lxo_gain(ddc_in[c].i, gain_ff);
      gq[c] = lxo_gain(ddc_in[c].q, gain_ff);
    end
  end

  // Output samples with their control bits, one decision per sample.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        ddc_out_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        ddc_out_ff[c].valid <= ddc_in[c].valid;
        if (ddc_in[c].valid) begin
          ddc_out_ff[c].i <= gi[c];
          ddc_out_ff[c].q <= gq[c];
          ddc_out_ff[c].i_ovr <= lxo_over(gi[c], i_thr_ff);
          ddc_out_ff[c].q_ovr <= lxo_over(gq[c], q_thr_ff);
        end
      end
    end
  end

  assign ddc_out = ddc_out_ff;

  // One-cycle hits feed the pin stretchers and the interrupt status.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      hit[2 * c] = ddc_out_ff[c].valid && ddc_out_ff[c].i_ovr;
      hit[2 * c + 1] = ddc_out_ff[c].valid && ddc_out_ff[c].q_ovr;
    end
  end

  lxo_stretch u_str_a_low (
    .pclk(pclk),
    .presetn(presetn),
    .hit(hit[0]),
    .enable(overrange_pin_enable_ff),
    .exponent(overrange_stretch_exponent_ff),
    .pin(overrange_out_a_low)
  );

  lxo_stretch u_str_a_high (
    .pclk(pclk),
    .presetn(presetn),
    .hit(hit[1]),
    .enable(overrange_pin_enable_ff),
    .exponent(overrange_stretch_exponent_ff),
    .pin(overrange_out_a_high)
  );

  lxo_stretch u_str_b_low (
    .pclk(pclk),
    .presetn(presetn),
    .hit(hit[2]),
    .enable(overrange_pin_enable_ff),
    .exponent(overrange_stretch_exponent_ff),
    .pin(overrange_out_b_low)
  );

  lxo_stretch u_str_b_high (
    .pclk(pclk),
    .presetn(presetn),
    .hit(hit[3]),
    .enable(overrange_pin_enable_ff),
    .exponent(overrange_stretch_exponent_ff),
    .pin(overrange_out_b_high)
  );

endmodule

// ### dv/lxo_props.sv
`timescale 1ns/1ns

// Port-level relations of the lane, header, sample and pin outputs.
module lxo_props (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link state.
  input wire logic link_format_64b66b,
  input wire logic [7:0] link_format_lanes_b,
  input wire logic [3:0] link_test_pattern_select,
  input wire logic [1:0] channel_power_down,
  // Watched outputs and streams.
  input wire lxo_pkg::lxo_lane_s lane_b [8],
  input wire lxo_pkg::lxo_sync_s sync_hdr,
  input wire lxo_pkg::lxo_sample_s ddc_in [2],
  input wire lxo_pkg::lxo_sample_out_s ddc_out [2],
  input wire logic overrange_out_a_low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A hit on the I stream, and the shortest legal pin pulse.
  sequence s_hit_a;
    ddc_out[0].valid && ddc_out[0].i_ovr;
  endsequence
  sequence s_pin_hold;
    overrange_out_a_low [*8];
  endsequence
  a_pd_kills_lanes: assert property (channel_power_down[1]
    |=> !lane_b[5].clk_en) else $error("lane on while powered down");
  a_ser_needs_clk: assert property (lane_b[3].ser_pwr
    |-> lane_b[3].clk_en) else $error("serializer without clocks");
  a_ser_clk_chain: assert property (lane_b[7].ser_clk |->
    lane_b[0].clk_en && lane_b[1].clk_en && lane_b[2].clk_en &&
    lane_b[3].clk_en && lane_b[4].clk_en && lane_b[5].clk_en &&
    lane_b[6].clk_en) else $error("serial clock with lower lane off");
  a_ramp_swap: assert property (!link_format_lanes_b[2] &&
    link_test_pattern_select inside {4'h0, 4'h5} |=>
    !lane_b[2].clk_en || lane_b[2].pattern == 4'h4)
    else $error("extension lane not on ramp");
  a_fmt_pattern: assert property (link_format_lanes_b[2] |=>
    lane_b[2].pattern == $past(link_test_pattern_select))
    else $error("format lane pattern wrong");
  a_sync_onehot: assert property ($onehot0({sync_hdr.crc_en,
    sync_hdr.fec_en, sync_hdr.reserved_mode})) else $error("mode clash");
  a_sync_64b_only: assert property (!link_format_64b66b |=>
    !sync_hdr.crc_en && !sync_hdr.fec_en) else $error("header outside 64b");
  a_cmd_idle: assert property (sync_hdr.cmd == 5'h00)
    else $error("command field not idle");
  a_sample_next: assert property (ddc_in[1].valid |=>
    ddc_out[1].valid) else $error("sample not passed on");
  a_pin_min_width: assert property ($rose(overrange_out_a_low)
    |-> s_pin_hold) else $error("pin pulse too short");
  a_pin_has_cause: assert property ($rose(overrange_out_a_low)
    |-> $past(ddc_out[0].valid && ddc_out[0].i_ovr))
    else $error("pin rose without hit");
  c_hit_pulse: cover property (s_hit_a ##1 s_pin_hold);
endmodule

bind lxo_top lxo_props lxo_props_i (.pclk(pclk), .presetn(presetn),
  .link_format_64b66b(link_format_64b66b),
  .link_format_lanes_b(link_format_lanes_b),
  .link_test_pattern_select(link_test_pattern_select),
  .channel_power_down(channel_power_down), .lane_b(lane_b),
  .sync_hdr(sync_hdr), .ddc_in(ddc_in), .ddc_out(ddc_out),
  .overrange_out_a_low(overrange_out_a_low));

// ### dv/lxo_rx_model.sv
`timescale 1ns/1ns

// Receiver view of link B: which lanes it can lock and what headers carry.
module lxo_rx_model (
  // Lane and header controls from the transmitter.
  input wire lxo_pkg::lxo_lane_s lane_b [8],
  input wire lxo_pkg::lxo_sync_s sync_hdr,
  // Receiver state.
  output logic [7:0] lanes_live,
  output logic hdr_checked
);
  // A lane locks only with a powered and clocked serializer, so a gap in
  // the lower lanes leaves every upper lane dark.
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      lanes_live[n] = lane_b[n].ser_pwr & lane_b[n].ser_clk;
    end
  end
  // Headers are checked only when a CRC or FEC code is carried.
  assign hdr_checked = sync_hdr.crc_en | sync_hdr.fec_en;
endmodule

// ### dv/test_lane_extension_overrange_config.sv
`timescale 1ns/1ns
`include "lxo_cfg.svh"

module test_lane_extension_overrange_config;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err, gain, hdr_checked;
  logic serial_link_enable = 1'b0, link_format_64b66b = 1'b0;
  logic [7:0] link_format_lanes_b = 8'h00, ti, tq, ext, fmt, lanes_live;
  logic [3:0] link_test_pattern_select = 4'h0, pat;
  logic [1:0] channel_power_down = 2'h0;
  logic [3:0] pins;
  logic [15:0] si;
  lxo_pkg::lxo_lane_s lane_b [8];
  lxo_pkg::lxo_sync_s sync_hdr;
  lxo_pkg::lxo_sample_s ddc_in [2];
  lxo_pkg::lxo_sample_out_s ddc_out [2];
  int mismatches = 0, compares = 0, cnt [4];
  lxo_pkg::lxo_lane_s el;
  logic [11:0] ridx [6] = '{`LXO_IDX_LANE_EXT, `LXO_IDX_SYNC_HDR,
    `LXO_IDX_DOWNCONVERTER_CONFIG, `LXO_IDX_I_THR, `LXO_IDX_Q_THR, `LXO_IDX_OVERRANGE_PIN_CONFIG};
  logic [7:0] rexp [6] = '{8'h00, 8'h00, 8'h00, 8'hf2, 8'hab, 8'h07};
  logic [7:0] pcfg [4] = '{8'h08, 8'h09, 8'h0a, 8'h00};
  int pexp [4] = '{8, 16, 32, 0};

  // Free-running bus clock.
  always #20 pclk = ~pclk;

  lxo_top lxo_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_link_enable(serial_link_enable),
    .link_format_64b66b(link_format_64b66b),
    .link_format_lanes_b(link_format_lanes_b),
    .link_test_pattern_select(link_test_pattern_select),
    .channel_power_down(channel_power_down), .lane_b(lane_b),
    .sync_hdr(sync_hdr), .ddc_in(ddc_in), .ddc_out(ddc_out),
    .overrange_out_a_low(pins[0]), .overrange_out_a_high(pins[1]),
    .overrange_out_b_low(pins[2]), .overrange_out_b_high(pins[3]),
    .irq(irq));
  lxo_rx_model lxo_rx_model_i (.lane_b(lane_b), .sync_hdr(sync_hdr),
    .lanes_live(lanes_live), .hdr_checked(hdr_checked));

  // Four-state compare so an unknown never counts as a match.
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait for pready is bounded only by the watchdog.
  task automatic apb(input logic w, input logic [11:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Saturating gain stage as the output should show it.
  function automatic logic [15:0] scale(logic [15:0] x, logic dbl);
    int s;
    s = $signed(x);
    if (dbl) s = s * 2;
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction

  // Level check against threshold over 256 of full scale.
  function automatic logic hit(logic [15:0] v, logic [7:0] t);
    int a;
    a = $signed(v);
    if (a < 0) a = -a;
    return a >= t * 128;
  endfunction

  // Expected lane controls from extension, format, pattern and power-down.
  function automatic lxo_pkg::lxo_lane_s exp_lane(int n, logic [7:0] e,
      logic [7:0] f, logic [3:0] p, logic pd);
    logic [7:0] on;
    lxo_pkg::lxo_lane_s r;
    on = pd ? 8'h00 : ({e[7:1], 1'b0} | f);
    r.clk_en = on[n];
    r.ser_pwr = on[n] & (f[n] | e[0]);
    r.ser_clk = r.ser_pwr & ((on | ~((8'h01 << n) - 8'h01)) == 8'hff);
    r.pattern = (!f[n] && on[n] && p inside {4'h0, 4'h5}) ? 4'h4 : p;
    return r;
  endfunction

  // One sample pair in, then the registered output is compared.
  task drive(input int c, input logic [15:0] i, input logic [15:0] q);
    @(posedge pclk);
    ddc_in[c] <= '{1'b1, i, q};
    @(posedge pclk);
    ddc_in[c].valid <= 1'b0;
    @(negedge pclk);
    check(ddc_out[c], {1'b1, scale(i, gain), hit(scale(i, gain), ti),
      scale(q, gain), hit(scale(q, gain), tq)});
  endtask

  task end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end

  // Main sequence: reset, then each area in turn.
  initial begin
    ddc_in[0] = '0;
    ddc_in[1] = '0;
    gain = 1'b0;
    ti = 8'hf2;
    tq = 8'hab;
    void'($urandom(32'h406fbc10));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      apb(1'b0, ridx[j], 32'h0);
      check(rd, rexp[j]);
    end
    apb(1'b0, 12'h300, 32'h0);
    check(err, 1'b1);
    $display("reset values done");
    // Pin width for stretch exponents 0 to 2, and the pin enable gate.
    apb(1'b1, `LXO_IDX_IRQ_MASK, 32'h1);
    // Channels alternate so every pin is seen; the idle pair stays low.
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, `LXO_IDX_OVERRANGE_PIN_CONFIG, pcfg[j]);
      drive(j % 2, 16'h7fff, 16'h7fff);
      cnt = '{0, 0, 0, 0};
      repeat (40) @(negedge pclk) begin
        for (int p = 0; p < 4; p++) cnt[p] += (pins[p] === 1'b1);
      end
      for (int p = 0; p < 4; p++)
        check(cnt[p], (p / 2 == j % 2) ? pexp[j] : 0);
    end
    check(irq, 1'b1);
    apb(1'b1, `LXO_IDX_IRQ_MASK, 32'h0);
    @(negedge pclk) check(irq, 1'b0);
    apb(1'b1, `LXO_IDX_IRQ_MASK, 32'h1);
    @(negedge pclk) check(irq, 1'b1);
    apb(1'b1, `LXO_IDX_IRQ_STS, 32'hff);
    @(negedge pclk) check(irq, 1'b0);
    apb(1'b1, `LXO_IDX_OVERRANGE_PIN_CONFIG, 32'h08);
    $display("pins and interrupt done");
    // Lane controls over random extension, format, pattern and power.
    for (int k = 0; k < 12; k++) begin
      ext = $urandom;
      fmt = $urandom;
      pat = (k % 3 == 0) ? 4'h0 : (k % 3 == 1) ? 4'h5 : 4'($urandom);
      @(posedge pclk);
      link_format_lanes_b <= fmt;
      link_test_pattern_select <= pat;
      channel_power_down <= {1'($urandom % 4 == 0), 1'b0};
      apb(1'b1, `LXO_IDX_LANE_EXT, ext);
      repeat (3) @(negedge pclk);
      for (int m = 0; m < 8; m++) begin
        el = exp_lane(m, ext, fmt, pat, channel_power_down[1]);
        check(lane_b[m], el);
        check(lanes_live[m], el.ser_clk);
      end
    end
    $display("lane controls done");
    // Every header mode with the link running; the write is flagged.
    @(posedge pclk);
    serial_link_enable <= 1'b1;
    link_format_64b66b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `LXO_IDX_SYNC_HDR, m);
      repeat (2) @(negedge pclk);
      check(sync_hdr, {m == 0, m == 2, 1'(m % 2), 5'h00});
      check(hdr_checked, m == 0 || m == 2);
    end
    apb(1'b0, `LXO_IDX_IRQ_STS, 32'h0);
    check(rd[4], 1'b1);
    link_format_64b66b <= 1'b0;
    apb(1'b1, `LXO_IDX_SYNC_HDR, 32'h0);
    repeat (2) @(negedge pclk);
    check(sync_hdr, 8'h00);
    @(posedge pclk);
    serial_link_enable <= 1'b0;
    $display("sync header done");
    // Samples with random thresholds and gain, exact threshold corners.
    ti = $urandom;
    tq = $urandom;
    apb(1'b1, `LXO_IDX_I_THR, ti);
    apb(1'b1, `LXO_IDX_Q_THR, tq);
    apb(1'b0, `LXO_IDX_I_THR, 32'h0);
    check(rd, ti);
    for (int k = 0; k < 14; k++) begin
      gain = (k < 2) ? 1'b0 : 1'($urandom);
      apb(1'b1, `LXO_IDX_DOWNCONVERTER_CONFIG, gain);
      si = (k == 0) ? {1'b0, ti, 7'h00} :
        (k == 1) ? {1'b0, ti, 7'h00} - 16'h0001 :
        (k == 2) ? 16'h8000 : (k == 3) ? 16'h7fff : 16'($urandom);
      drive(k % 2, si, 16'($urandom));
    end
    $display("samples done");
    end_sim();
  end
endmodule
